// ==== verilog/io_port_function_select.sv ====
// port function select top: wishbone registers and pin role logic
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/10ps

// Contract
// [R1] two function select registers route pins to peripheral or gpio
// [R2] select bit zero gives dedicated signal, one gives general-purpose pin
// [R3] irq and dma pin roles come from their own config registers
// [R4] low select register, read/write, pins 0-31, reset 0x0fffff00
// [R5] high select register, read/write, pins 32-63, reset zero
// [R6] direction bits 12..0 of both direction registers reset to one
// [R7] direction one is input, zero drives the gpio pin
module io_port_function_select
  import io_port_function_select_pkg::*;
#(
  parameter int unsigned PINS = PORT_PINS
) (
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  // wishbone classic slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] adr_i,
  input  wire logic [SEL_W-1:0]  sel_i,
  input  wire logic [DATA_W-1:0] dat_i,
  output logic      [DATA_W-1:0] dat_o,
  output logic                   ack_o,
  // package pins
  input  wire logic [PINS-1:0]   pad_i,
  output logic      [PINS-1:0]   pad_o,
  output logic      [PINS-1:0]   pad_oe_n_o,
  // on-chip peripherals
  input  wire logic [PINS-1:0]   periph_out_i,
  input  wire logic [PINS-1:0]   periph_oe_i,
  output logic      [PINS-1:0]   periph_in_o,
  // gpio data path
  input  wire logic [PINS-1:0]   gpio_out_i,
  output logic      [PINS-1:0]   gpio_in_o
);

  // ------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------
  // two 32-bit select registers cover exactly the port
  if (PINS != 2 * DATA_W) begin : g_bad_pins
    $error("pin count must equal two register words");
  end

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  bus_state_t        bus_state_reg;
  bus_state_t        bus_state_next;
  logic [DATA_W-1:0] rd_data_next;
  logic              req;
  logic              wr_take;
  logic [DATA_W-1:0] sel_low_reg;
  logic [DATA_W-1:0] sel_high_reg;
  logic [DATA_W-1:0] dir_low_reg;
  logic [DATA_W-1:0] dir_high_reg;
  logic [DATA_W-1:0] irq_cfg_reg;
  logic [DATA_W-1:0] dma_cfg_reg;
  logic              hit_sel_low;
  logic              hit_sel_high;
  logic              hit_dir_low;
  logic              hit_dir_high;
  logic              hit_irq_cfg;
  logic              hit_dma_cfg;
  logic [PINS-1:0]   gpio_sel;
  logic [PINS-1:0]   dir_in;
  logic [PINS-1:0]   cfg_mask;
  logic [PINS-1:0]   cfg_drive;
  logic [PINS-1:0]   cfg_in_en;
  logic [PINS-1:0]   ded_drive;
  logic [PINS-1:0]   ded_in_en;
  logic [PINS-1:0]   pin_level;

  // ------------------------------------------------------------
  // byte-lane merge for writes
  // ------------------------------------------------------------
  function automatic logic [DATA_W-1:0] lane_merge(
    input logic [DATA_W-1:0] old_val,
    input logic [DATA_W-1:0] new_val,
    input logic [SEL_W-1:0]  lanes
  );
    logic [DATA_W-1:0] res;
    res = old_val;
    for (int b = 0; b < SEL_W; b++) begin
      if (lanes[b]) begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  // word compare; low address bits are covered by sel_i
  assign hit_sel_low  = adr_i[ADDR_W-1:ADDR_LSB] == SEL_LOW_ADDR[ADDR_W-1:ADDR_LSB];
  assign hit_sel_high = adr_i[ADDR_W-1:ADDR_LSB] == SEL_HIGH_ADDR[ADDR_W-1:ADDR_LSB];
  assign hit_dir_low  = adr_i[ADDR_W-1:ADDR_LSB] == DIR_LOW_ADDR[ADDR_W-1:ADDR_LSB];
  assign hit_dir_high = adr_i[ADDR_W-1:ADDR_LSB] == DIR_HIGH_ADDR[ADDR_W-1:ADDR_LSB];
  assign hit_irq_cfg  = adr_i[ADDR_W-1:ADDR_LSB] == IRQ_CFG_ADDR[ADDR_W-1:ADDR_LSB];
  assign hit_dma_cfg  = adr_i[ADDR_W-1:ADDR_LSB] == DMA_CFG_ADDR[ADDR_W-1:ADDR_LSB];

  // request and write commit strobes
  assign req = cyc_i & stb_i;
  // write lands on the edge where the master sees ack high
  assign wr_take = req & we_i & (bus_state_reg == BUS_ACK);

  // ------------------------------------------------------------
  // bus slave state machine
  // ------------------------------------------------------------
  // one wait state: ack one edge after the request is seen
  always_comb begin
    bus_state_next = bus_state_reg;
    unique case (bus_state_reg)
      BUS_IDLE: begin
        if (req) begin
          bus_state_next = BUS_ACK;
        end
      end
      BUS_ACK: begin
        bus_state_next = BUS_IDLE;
      end
      default: begin
        bus_state_next = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus_state_reg <= BUS_IDLE;
    end else begin
      bus_state_reg <= bus_state_next;
    end
  end

  // ack is a single-cycle pulse per request
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= (bus_state_reg == BUS_IDLE) & req;
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  // unmapped words read zero and still acknowledge
  always_comb begin
    rd_data_next = UNMAPPED_RD;
    if (hit_sel_low) begin
      rd_data_next = sel_low_reg;
    end else if (hit_sel_high) begin
      rd_data_next = sel_high_reg;
    end else if (hit_dir_low) begin
      rd_data_next = dir_low_reg;
    end else if (hit_dir_high) begin
      rd_data_next = dir_high_reg;
    end else if (hit_irq_cfg) begin
      rd_data_next = irq_cfg_reg;
    end else if (hit_dma_cfg) begin
      rd_data_next = dma_cfg_reg;
    end
  end

  // data captured with the ack so it is stable while ack is high
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dat_o <= '0;
    end else if ((bus_state_reg == BUS_IDLE) & req & ~we_i) begin
      dat_o <= rd_data_next;
    end else if (bus_state_reg == BUS_ACK) begin
      dat_o <= '0;
    end
  end

  // ------------------------------------------------------------
  // function select registers
  // ------------------------------------------------------------
  // [R4] low select, pins 0-31
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sel_low_reg <= SEL_LOW_RST;
    end else if (wr_take & hit_sel_low) begin
      sel_low_reg <= lane_merge(sel_low_reg, dat_i, sel_i);
    end
  end

  // [R5] high select, pins 32-63
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sel_high_reg <= SEL_HIGH_RST;
    end else if (wr_take & hit_sel_high) begin
      sel_high_reg <= lane_merge(sel_high_reg, dat_i, sel_i);
    end
  end

  // ------------------------------------------------------------
  // direction registers
  // ------------------------------------------------------------
  // [R6] low bits come up as inputs
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dir_low_reg <= DIR_LOW_RST;
    end else if (wr_take & hit_dir_low) begin
      dir_low_reg <= lane_merge(dir_low_reg, dat_i, sel_i);
    end
  end

  // [R6] high bank starts as inputs
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dir_high_reg <= DIR_HIGH_RST;
    end else if (wr_take & hit_dir_high) begin
      dir_high_reg <= lane_merge(dir_high_reg, dat_i, sel_i);
    end
  end

  // ------------------------------------------------------------
  // irq and dma pin config registers
  // ------------------------------------------------------------
  // unused bits kept as storage, they read back as written
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_cfg_reg <= IRQ_CFG_RST;
    end else if (wr_take & hit_irq_cfg) begin
      irq_cfg_reg <= lane_merge(irq_cfg_reg, dat_i, sel_i);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dma_cfg_reg <= DMA_CFG_RST;
    end else if (wr_take & hit_dma_cfg) begin
      dma_cfg_reg <= lane_merge(dma_cfg_reg, dat_i, sel_i);
    end
  end

  // ------------------------------------------------------------
  // pin role vectors
  // ------------------------------------------------------------
  // [R1] two words form one per-pin select vector
  assign gpio_sel = {sel_high_reg, sel_low_reg};
  assign dir_in   = {dir_high_reg, dir_low_reg};

  // per pin: does a config register own the role, and what is it
  for (genvar p = 0; p < PINS; p++) begin : g_role
    if (p >= IRQ_PIN_BASE && p < IRQ_PIN_BASE + IRQ_PIN_NUM) begin : g_irq
      // [R3] irq pin is input when enabled
      assign cfg_mask[p]  = 1'b1;
      assign cfg_drive[p] = 1'b0;
      assign cfg_in_en[p] = irq_cfg_reg[p - IRQ_PIN_BASE];
    end else if (p >= DMA_REQ_BASE && p < DMA_REQ_BASE + DMA_CH_NUM) begin : g_req
      // [R3] dma request pin is input when enabled
      assign cfg_mask[p]  = 1'b1;
      assign cfg_drive[p] = 1'b0;
      assign cfg_in_en[p] = dma_cfg_reg[p - DMA_REQ_BASE];
    end else if (p >= DMA_ACK_BASE && p < DMA_ACK_BASE + DMA_CH_NUM) begin : g_ack
      // [R3] dma ack pin is driven when enabled
      assign cfg_mask[p]  = 1'b1;
      assign cfg_drive[p] = dma_cfg_reg[DMA_ACK_CFG_BASE + p - DMA_ACK_BASE];
      assign cfg_in_en[p] = 1'b0;
    end else begin : g_plain
      // other peripherals state their own direction
      assign cfg_mask[p]  = 1'b0;
      assign cfg_drive[p] = 1'b0;
      assign cfg_in_en[p] = 1'b1;
    end
  end

  // [R3] config register overrides peripheral direction
  assign ded_drive = (cfg_mask & cfg_drive) | (~cfg_mask & periph_oe_i);
  assign ded_in_en = cfg_in_en;

  // ------------------------------------------------------------
  // pin input synchroniser
  // ------------------------------------------------------------
  pin_input_sync #(
    .WIDTH (PINS)
  ) u_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .pin_i    (pad_i),
    .level_o  (pin_level)
  );

  // ------------------------------------------------------------
  // pin routing cells
  // ------------------------------------------------------------
  // [R2] mux per pin, outputs registered inside
  pin_route #(
    .PINS (PINS)
  ) u_route (
    .clk_i        (clk_i),
    .resetn_i     (resetn_i),
    .gpio_sel_i   (gpio_sel),
    .dir_in_i     (dir_in),
    .ded_drive_i  (ded_drive),
    .ded_in_en_i  (ded_in_en),
    .periph_out_i (periph_out_i),
    .gpio_out_i   (gpio_out_i),
    .level_i      (pin_level),
    .pad_o        (pad_o),
    .pad_oe_n_o   (pad_oe_n_o),
    .periph_in_o  (periph_in_o),
    .gpio_in_o    (gpio_in_o)
  );

endmodule

// ==== shared/io_port_function_select_pkg.sv ====
// constants, register map and types of the port function select block
package io_port_function_select_pkg;

  // --------------------------------------------------------------
  // bus geometry
  // --------------------------------------------------------------
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned SEL_W    = 4;
  localparam int unsigned ADDR_W   = 32;
  localparam int unsigned ADDR_LSB = 2;
  localparam int unsigned PORT_PINS = 64;

  // --------------------------------------------------------------
  // register byte addresses
  // --------------------------------------------------------------
  localparam logic [31:0] DIR_LOW_ADDR  = 32'hf0030000;
  localparam logic [31:0] DIR_HIGH_ADDR = 32'hf0030004;
  localparam logic [31:0] SEL_LOW_ADDR  = 32'hf0030008;
  localparam logic [31:0] SEL_HIGH_ADDR = 32'hf003000c;
  localparam logic [31:0] IRQ_CFG_ADDR  = 32'hf0030010;
  localparam logic [31:0] DMA_CFG_ADDR  = 32'hf0030014;

  // --------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------
  localparam logic [31:0] SEL_LOW_RST  = 32'h0fffff00;
  localparam logic [31:0] SEL_HIGH_RST = 32'h00000000;
  localparam logic [31:0] DIR_LOW_RST  = 32'hf003ffff;
  localparam logic [31:0] DIR_HIGH_RST = 32'hffffffff;
  localparam logic [31:0] IRQ_CFG_RST  = 32'h00000000;
  localparam logic [31:0] DMA_CFG_RST  = 32'h00000000;
  localparam logic [31:0] UNMAPPED_RD  = 32'h00000000;

  // --------------------------------------------------------------
  // pins whose role comes from the irq and dma config registers
  // --------------------------------------------------------------
  localparam int unsigned IRQ_PIN_BASE     = 8;
  localparam int unsigned IRQ_PIN_NUM      = 6;
  localparam int unsigned DMA_REQ_BASE     = 14;
  localparam int unsigned DMA_ACK_BASE     = 18;
  localparam int unsigned DMA_CH_NUM       = 4;
  localparam int unsigned DMA_ACK_CFG_BASE = 4;

  // bus slave state, gray along idle -> ack
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } bus_state_t;

endpackage

// ==== verilog/pin_input_sync.sv ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module pin_input_sync #(
  parameter int unsigned WIDTH = 64
) (
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;

  // -----------------------------------------------------------
  // shift chain; stage1 only feeds stage2
  // -----------------------------------------------------------
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
    end else begin
      stage1_reg <= pin_i;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // a change counts only once stage2 and stage3 agree
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      level_o <= '0;
    end else begin
      level_o <= (stage2_reg & stage3_reg) | (level_o & (stage2_reg | stage3_reg));
    end
  end

endmodule

// ==== verilog/pin_route.sv ====
// per-pin routing between pad, peripheral signal and gpio
`timescale 1ns/10ps
module pin_route #(
  parameter int unsigned PINS = 64
) (
  input  wire logic            clk_i,
  input  wire logic            resetn_i,
  input  wire logic [PINS-1:0] gpio_sel_i,
  input  wire logic [PINS-1:0] dir_in_i,
  input  wire logic [PINS-1:0] ded_drive_i,
  input  wire logic [PINS-1:0] ded_in_en_i,
  input  wire logic [PINS-1:0] periph_out_i,
  input  wire logic [PINS-1:0] gpio_out_i,
  input  wire logic [PINS-1:0] level_i,
  output logic      [PINS-1:0] pad_o,
  output logic      [PINS-1:0] pad_oe_n_o,
  output logic      [PINS-1:0] periph_in_o,
  output logic      [PINS-1:0] gpio_in_o
);

  // -----------------------------------------------------------
  // one routing cell per pin
  // -----------------------------------------------------------
  for (genvar p = 0; p < PINS; p++) begin : g_pin
    // [R2] zero dedicated, one gpio
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        pad_o[p] <= 1'b0;
      end else begin
        pad_o[p] <= gpio_sel_i[p] ? gpio_out_i[p] : periph_out_i[p];
      end
    end

    // [R7] direction one means input
    // released pads sit undriven, safe default for unknown boards
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        pad_oe_n_o[p] <= 1'b1;
      end else if (gpio_sel_i[p]) begin
        pad_oe_n_o[p] <= dir_in_i[p];
      end else begin
        pad_oe_n_o[p] <= ~ded_drive_i[p];
      end
    end

    // [R3] peripheral sees pin only in its role
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        periph_in_o[p] <= 1'b0;
      end else begin
        periph_in_o[p] <= ~gpio_sel_i[p] & ded_in_en_i[p] & level_i[p];
      end
    end

    // gpio input readback follows the pad in any mode
    always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        gpio_in_o[p] <= 1'b0;
      end else begin
        gpio_in_o[p] <= level_i[p];
      end
    end
  end

endmodule

// ==== sim/io_port_function_select_monitor.sv ====
// assertion checker for the port function select block
`timescale 1ns/10ps
module io_port_function_select_monitor
  import io_port_function_select_pkg::*;
#(
  parameter int unsigned PINS = 64
) (
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] adr_i,
  input  wire logic [SEL_W-1:0]  sel_i,
  input  wire logic [DATA_W-1:0] dat_i,
  input  wire logic [DATA_W-1:0] dat_o,
  input  wire logic              ack_o,
  input  wire logic [PINS-1:0]   pad_o,
  input  wire logic [PINS-1:0]   pad_oe_n_o,
  input  wire logic [PINS-1:0]   periph_out_i,
  input  wire logic [PINS-1:0]   periph_oe_i,
  input  wire logic [PINS-1:0]   periph_in_o,
  input  wire logic [PINS-1:0]   gpio_out_i
);
  logic [31:0] sel_hi_q;
  logic [31:0] dir_hi_q;
  logic        live_q;
  logic        rd_ack;
  assign rd_ack = ack_o && !we_i;

  // shadow of the high registers, merged lane by lane at the ack edge
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sel_hi_q <= SEL_HIGH_RST;
      dir_hi_q <= DIR_HIGH_RST;
    end else if (cyc_i && stb_i && we_i && ack_o) begin
      for (int b = 0; b < 4; b++) begin
        if (sel_i[b] && adr_i[31:2] == SEL_HIGH_ADDR[31:2]) sel_hi_q[b*8 +: 8] <= dat_i[b*8 +: 8];
        if (sel_i[b] && adr_i[31:2] == DIR_HIGH_ADDR[31:2]) dir_hi_q[b*8 +: 8] <= dat_i[b*8 +: 8];
      end
    end
  end

  // pin flops hold reset values on the first edge, so skip it
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) live_q <= 1'b0;
    else live_q <= 1'b1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_bus_req;
    cyc_i && stb_i && !ack_o;
  endsequence

  a_ack_next_edge: assert property (s_bus_req |=> ack_o) else $error("no ack after request");
  a_ack_one_cycle: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  a_dat_idle_zero: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data outside ack");
  a_high_sel_read: assert property (rd_ack && adr_i[31:2] == SEL_HIGH_ADDR[31:2] |-> dat_o == sel_hi_q)
    else $error("high select readback wrong");
  a_high_dir_read: assert property (rd_ack && adr_i[31:2] == DIR_HIGH_ADDR[31:2] |-> dat_o == dir_hi_q)
    else $error("high direction readback wrong");
  a_high_periph_out: assert property (live_q |->
    ((pad_o[63:32] ^ $past(periph_out_i[63:32])) & ~$past(sel_hi_q)) == 32'h0) else $error("periph value lost");
  a_high_periph_oe: assert property (live_q |->
    ((pad_oe_n_o[63:32] ^ ~$past(periph_oe_i[63:32])) & ~$past(sel_hi_q)) == 32'h0) else $error("periph oe lost");
  a_high_gpio_dir: assert property (live_q |->
    ((pad_oe_n_o[63:32] ^ $past(dir_hi_q)) & $past(sel_hi_q)) == 32'h0) else $error("gpio direction wrong");
  a_high_gpio_data: assert property (live_q |->
    ((pad_o[63:32] ^ $past(gpio_out_i[63:32])) & $past(sel_hi_q) & ~$past(dir_hi_q)) == 32'h0)
    else $error("gpio output wrong");
  a_high_in_masked: assert property (live_q |-> (periph_in_o[63:32] & $past(sel_hi_q)) == 32'h0)
    else $error("peripheral sees gpio pin");
endmodule

// ==== sim/io_port_far_side.sv ====
// far side model: external pin drivers and on-chip peripheral outputs
`timescale 1ns/10ps
module io_port_far_side (
  input  wire logic [63:0] pad_out_i,
  input  wire logic [63:0] pad_oe_n_i,
  input  wire logic [63:0] ext_level_i,
  input  wire logic [63:0] periph_val_i,
  input  wire logic [63:0] periph_en_i,
  output logic      [63:0] pad_level_o,
  output logic      [63:0] periph_val_o,
  output logic      [63:0] periph_en_o
);
  // a driven pad wins; a released pad shows the outside device's level
  assign pad_level_o  = (pad_out_i & ~pad_oe_n_i) | (ext_level_i & pad_oe_n_i);
  // peripherals present value and drive request every cycle
  assign periph_val_o = periph_val_i;
  assign periph_en_o  = periph_en_i;
endmodule

// ==== sim/io_port_function_select_tb.sv ====
// self-checking bench for the port function select block
`timescale 1ns/10ps
module io_port_function_select_tb;
  import io_port_function_select_pkg::*;
  logic        clk_i, resetn_i, cyc_i, stb_i, we_i, ack_o;
  logic [31:0] adr_i, dat_i, dat_o, q;
  logic [3:0]  sel_i;
  logic [63:0] pad_i, pad_o, pad_oe_n_o, periph_out_i, periph_oe_i, periph_in_o, gpio_out_i, gpio_in_o;
  logic [63:0] ext_level, periph_val, periph_en;
  int          failures, total_checks, cycles;

  io_port_function_select io_port_function_select_inst (.clk_i(clk_i), .resetn_i(resetn_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .pad_i(pad_i), .pad_o(pad_o), .pad_oe_n_o(pad_oe_n_o), .periph_out_i(periph_out_i),
    .periph_oe_i(periph_oe_i), .periph_in_o(periph_in_o), .gpio_out_i(gpio_out_i), .gpio_in_o(gpio_in_o));
  io_port_far_side io_port_far_side_inst (.pad_out_i(pad_o), .pad_oe_n_i(pad_oe_n_o), .ext_level_i(ext_level),
    .periph_val_i(periph_val), .periph_en_i(periph_en), .pad_level_o(pad_i), .periph_val_o(periph_out_i),
    .periph_en_o(periph_oe_i));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // hang guard, far above the fewer than a hundred cycles the run needs
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      close_out();
    end
  end

  // one classic cycle; request held until ack is sampled high
  task automatic xfer(input logic w, input logic [31:0] a, input logic [3:0] s, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    // no cycle budget here: only the hang guard ends a lost answer
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic t_reset_vals;
    xfer(1'b0, SEL_LOW_ADDR, 4'hf, 32'h0);
    check(q, 32'h0fffff00);
    xfer(1'b0, SEL_HIGH_ADDR, 4'hf, 32'h0);
    check(q, 32'h0);
    xfer(1'b0, DIR_LOW_ADDR, 4'hf, 32'h0);
    check(q & 32'h1fff, 32'h1fff);
    xfer(1'b0, DIR_HIGH_ADDR, 4'hf, 32'h0);
    check(q & 32'h1fff, 32'h1fff);
    xfer(1'b0, 32'hf0030040, 4'hf, 32'h0);
    check(q, 32'h0);
  endtask

  task automatic t_lanes;
    xfer(1'b1, SEL_HIGH_ADDR, 4'b0101, 32'ha5a5a5a5);
    xfer(1'b0, SEL_HIGH_ADDR, 4'hf, 32'h0);
    check(q, 32'h00a500a5);
    xfer(1'b1, SEL_LOW_ADDR, 4'hf, 32'hffffffff);
    xfer(1'b0, SEL_LOW_ADDR, 4'hf, 32'h0);
    check(q, 32'hffffffff);
    // pins 8, 14 and 18 back on their dedicated signals
    xfer(1'b1, SEL_LOW_ADDR, 4'hf, 32'h0ffbbe00);
  endtask

  // pins 32-47 gpio (32-39 in, 40-47 out), 48-63 dedicated
  task automatic t_high_route;
    xfer(1'b1, SEL_HIGH_ADDR, 4'hf, 32'h0000ffff);
    xfer(1'b1, DIR_HIGH_ADDR, 4'hf, 32'h000000ff);
    settle(2);
    check(pad_oe_n_o[63:32], {~periph_en[63:48], 16'h00ff});
    check(pad_o[47:40], gpio_out_i[47:40]);
    check(pad_o[63:48], periph_val[63:48]);
    check({pad_o[28], pad_oe_n_o[28]}, 2'b10);
  endtask

  // pin 33 gpio input, pin 50 released dedicated, 14 dma request, 18 dma ack, 8 irq
  task automatic t_inputs(input logic lvl);
    @(posedge clk_i);
    ext_level <= {64{lvl}};
    settle(5);
    check({gpio_in_o[33], periph_in_o[33], periph_in_o[50]}, {lvl, 1'b0, lvl});
    check({pad_oe_n_o[14], pad_oe_n_o[8], pad_oe_n_o[18], periph_in_o[14], periph_in_o[8]}, {3'b110, lvl, lvl});
  endtask

  initial begin
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = '0;
    resetn_i = 1'b0;
    failures = 0;
    total_checks = 0;
    cycles = 0;
    ext_level = 64'h0;
    gpio_out_i = 64'h0000_a500_0000_0000;
    periph_val = 64'h5a5a_0000_1000_0000;
    periph_en = 64'h0f0b_0000_1000_0100;
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_reset_vals();
    t_lanes();
    t_high_route();
    // request channel 0 and ack channel 0 on, irq line 0 on
    xfer(1'b1, DMA_CFG_ADDR, 4'hf, 32'h00000011);
    xfer(1'b1, IRQ_CFG_ADDR, 4'hf, 32'h00000001);
    t_inputs(1'b1);
    t_inputs(1'b0);
    @(posedge clk_i);
    resetn_i <= 1'b0;
    settle(2);
    check(pad_oe_n_o, {64{1'b1}});
    @(posedge clk_i);
    resetn_i <= 1'b1;
    xfer(1'b0, SEL_HIGH_ADDR, 4'hf, 32'h0);
    check(q, 32'h0);
    // reset roles: 27-18 gpio outputs, 17-8 gpio inputs, 28 driven by its peripheral
    check(pad_oe_n_o[31:0], 32'he003ffff);
    close_out();
  end
endmodule

bind io_port_function_select io_port_function_select_monitor #(.PINS(PINS)) io_port_function_select_monitor_inst (
  .clk_i(clk_i), .resetn_i(resetn_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pad_o(pad_o), .pad_oe_n_o(pad_oe_n_o),
  .periph_out_i(periph_out_i), .periph_oe_i(periph_oe_i), .periph_in_o(periph_in_o), .gpio_out_i(gpio_out_i));
